// File: logic/cbs_companion_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Own configuration is read from the shared flash before the companion may fetch firmware.
// - The companion stays in reset for the whole configuration read so the flash has one user.
// - General-purpose pin zero only drives the active-low companion hold line.
// - The hold line stays asserted at least 100 us after the companion supply is valid.
// - The second I2C port is target only and answers address 0x38 from the companion.
// - With a connection present the device interrupts the companion, which reads status over I2C.
// - Cable orientation drives both route selects of the sideband mux.
// - DisplayPort mode drives the mux enable for the auxiliary pair.
// - Exactly one fixed source offer of 5 V at 3 A is advertised.
// - Sink offers are fixed 5, 9, 15 and 20 V at 3 A each.
// - In a dual-mode dock the sink path is on when bus powered, source path when self powered and attached.
module cbs_companion_ctrl
    import cbs_pkg::*;
#(
    parameter int HOLD_CYC = HOLD_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        cfg_load_busy,
    input  wire logic        companion_supply_rail,
    input  wire logic        release_on_boot_en,
    input  wire logic        system_boot_ok,
    output logic             flash_grant_companion,
    output logic             companion_hold_line_n,
    input  wire logic        attached,
    input  wire logic        plug_flipped,
    input  wire logic        dp_mode,
    input  wire logic        fast_link_mode,
    input  wire logic        usb3_mode,
    input  wire logic        dual_mode_dock,
    input  wire logic        ext_power_good,
    output logic             mux_route_aux_sel,
    output logic             mux_route_link_sel,
    output logic             mux_gate_aux_path,
    output logic             mux_gate_sideband_link,
    output logic             sink_power_path,
    output logic             source_power_path,
    output logic             companion_irq,
    input  wire logic        target_scl,
    input  wire logic        target_sda_in,
    output logic             target_sda_out,
    output logic             target_sda_oe,
    input  wire logic [2:0]  pdo_index,
    input  wire logic        pdo_is_sink,
    output logic [2:0]       pdo_count,
    output logic [9:0]       pdo_mv50,
    output logic [9:0]       pdo_ma10
);
    // ========================================================
    // Pin synchronisers
    // ========================================================
    localparam int NSYNC = 4;
    // Bus pins idle high; a low reset value would fake a bus edge.
    localparam logic [NSYNC-1:0] SYNC_IDLE = 4'h3;
    wire  [NSYNC-1:0] raw_in = {companion_supply_rail, system_boot_ok,
                                target_scl, target_sda_in};
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;

    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            always_ff @(posedge clk) begin
                if (reset) begin
                    sync1_q[i] <= SYNC_IDLE[i];
                    sync2_q[i] <= SYNC_IDLE[i];
                end else if (ce) begin
                    sync1_q[i] <= raw_in[i];
                    sync2_q[i] <= sync1_q[i];
                end
            end
        end
    endgenerate

    wire supply_ok = sync2_q[3];
    wire boot_ok   = sync2_q[2];
    wire scl_s     = sync2_q[1];
    wire sda_s     = sync2_q[0];

    // ========================================================
    // Boot ordering and companion hold
    // ========================================================
    cbs_boot_t            boot_q;
    logic [HOLD_CNT_W-1:0] hold_cnt_q;
    wire hold_done = (hold_cnt_q >= HOLD_CNT_W'(HOLD_CYC - 1));
    wire gate_ok   = ~release_on_boot_en | boot_ok;

    always_ff @(posedge clk) begin
        if (reset) begin
            boot_q     <= CBS_ST_CFG_LOAD;
            hold_cnt_q <= '0;
        end else if (ce) begin
            unique case (boot_q)
                CBS_ST_CFG_LOAD: begin
                    if (!cfg_load_busy) begin
                        boot_q <= CBS_ST_WAIT_SUPPLY;
                    end
                end
                CBS_ST_WAIT_SUPPLY: begin
                    hold_cnt_q <= '0;
                    if (supply_ok) begin
                        boot_q <= CBS_ST_SETTLE;
                    end
                end
                CBS_ST_SETTLE: begin
                    if (!supply_ok) begin
                        boot_q <= CBS_ST_WAIT_SUPPLY;
                    end else if (hold_done) begin
                        boot_q <= CBS_ST_RUN;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + HOLD_CNT_W'(1);
                    end
                end
                // A supply drop re-arms the hold and its timer.
                CBS_ST_RUN: begin
                    if (!supply_ok) begin
                        boot_q <= CBS_ST_WAIT_SUPPLY;
                    end
                end
            endcase
        end
    end

    wire run = (boot_q == CBS_ST_RUN);

    assign flash_grant_companion = run;
    // pin zero is hold only; release after boot
    assign companion_hold_line_n = run & gate_ok;

    // ========================================================
    // Sideband mux events
    // ========================================================
    logic flip_q, dp_q, fl_q, usb3_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            flip_q <= 1'b0;
            dp_q   <= 1'b0;
            fl_q   <= 1'b0;
            usb3_q <= 1'b0;
        end else if (ce) begin
            flip_q <= attached & plug_flipped;
            dp_q   <= attached & dp_mode;
            fl_q   <= attached & fast_link_mode;
            usb3_q <= attached & usb3_mode;
        end
    end

    assign mux_route_aux_sel      = flip_q;
    assign mux_route_link_sel     = flip_q;
    assign mux_gate_aux_path      = dp_q;
    assign mux_gate_sideband_link = fl_q;

    // ========================================================
    // Power paths
    // ========================================================
    logic sink_q, src_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            sink_q <= 1'b0;
            src_q  <= 1'b0;
        end else if (ce) begin
            sink_q <= dual_mode_dock & ~ext_power_good;
            src_q  <= dual_mode_dock & ext_power_good & attached;
        end
    end
    assign sink_power_path   = sink_q;
    assign source_power_path = src_q;

    // ========================================================
    // Status target and companion interrupt
    // ========================================================
    logic [STATUS_W-1:0] status;
    always_comb begin
        status               = '0;
        status[ST_ATTACHED]  = attached;
        status[ST_FLIP]      = flip_q;
        status[ST_DP_MODE]   = dp_q;
        status[ST_FAST_LINK] = fl_q;
        status[ST_USB3]      = usb3_q;
        status[ST_BOOT_DONE] = run;
        status[ST_SINK_PATH] = sink_q;
        status[ST_SRC_PATH]  = src_q;
    end

    logic read_done;
    logic irq_q;
    logic [STATUS_W-1:0] seen_q;

    cbs_i2c_target u_target (
        .clk         (clk),
        .reset       (reset),
        .ce          (ce),
        .scl_s       (scl_s),
        .sda_s       (sda_s),
        .status_byte (status),
        .sda_oe      (target_sda_oe),
        .read_done   (read_done)
    );
    assign target_sda_out = 1'b0;

    // Interrupt rises on any status change while attached; a change
    // arriving in the same cycle as a completed read wins over the clear.
    wire changed = (status != seen_q);
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q  <= 1'b0;
            seen_q <= '0;
        end else if (ce) begin
            seen_q <= status;
            if (changed && status[ST_ATTACHED]) begin
                irq_q <= 1'b1;
            end else if (read_done || !attached) begin
                irq_q <= 1'b0;
            end
        end
    end
    assign companion_irq = irq_q;

    // ========================================================
    // Power offers
    // ========================================================
    logic [2:0] cnt_q;
    logic [9:0] mv_q, ma_q;
    wire  [9:0] snk_mv = (pdo_index == 3'h0) ? MV50_5V  :
                         (pdo_index == 3'h1) ? MV50_9V  :
                         (pdo_index == 3'h2) ? MV50_15V :
                         (pdo_index == 3'h3) ? MV50_20V : 10'h000;
    wire        idx_ok = pdo_is_sink ? (pdo_index < SNK_PDO_NUM)
                                     : (pdo_index < SRC_PDO_NUM);
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= 3'h0;
            mv_q  <= 10'h000;
            ma_q  <= 10'h000;
        end else if (ce) begin
            // single source offer; four sink offers
            cnt_q <= pdo_is_sink ? SNK_PDO_NUM : SRC_PDO_NUM;
            mv_q  <= !idx_ok ? 10'h000 :
                     (pdo_is_sink ? snk_mv : MV50_5V);
            ma_q  <= idx_ok ? MA10_3A : 10'h000;
        end
    end
    assign pdo_count = cnt_q;
    assign pdo_mv50  = mv_q;
    assign pdo_ma10  = ma_q;

endmodule : cbs_companion_ctrl

// File: logic/cbs_pkg.sv
package cbs_pkg;

    // ========================================================
    // Target port
    // ========================================================
    localparam logic [6:0] TARGET_ADDR      = 7'h38;
    localparam int         STATUS_W         = 8;

    // Status byte field positions.
    localparam int ST_ATTACHED   = 0;
    localparam int ST_FLIP       = 1;
    localparam int ST_DP_MODE    = 2;
    localparam int ST_FAST_LINK  = 3;
    localparam int ST_USB3       = 4;
    localparam int ST_BOOT_DONE  = 5;
    localparam int ST_SINK_PATH  = 6;
    localparam int ST_SRC_PATH   = 7;

    // ========================================================
    // Timing
    // ========================================================
    localparam int CLK_HZ           = 10_000_000;
    localparam int HOLD_AFTER_SUPPLY_US = 100;
    localparam int HOLD_CYCLES =
        (HOLD_AFTER_SUPPLY_US * (CLK_HZ / 1_000_000) > 0) ?
        HOLD_AFTER_SUPPLY_US * (CLK_HZ / 1_000_000) : 1;
    localparam int HOLD_CNT_W       = 11;

    // ========================================================
    // Power objects: voltage in 50 mV units, current in 10 mA
    // ========================================================
    localparam int          PDO_COUNT_W  = 3;
    localparam logic [9:0]  MV50_5V      = 10'h064;
    localparam logic [9:0]  MV50_9V      = 10'h0B4;
    localparam logic [9:0]  MV50_15V     = 10'h12C;
    localparam logic [9:0]  MV50_20V     = 10'h190;
    localparam logic [9:0]  MA10_3A      = 10'h12C;
    localparam logic [2:0]  SRC_PDO_NUM  = 3'h1;
    localparam logic [2:0]  SNK_PDO_NUM  = 3'h4;

    typedef enum logic [1:0] {
        CBS_ST_CFG_LOAD,
        CBS_ST_WAIT_SUPPLY,
        CBS_ST_SETTLE,
        CBS_ST_RUN
    } cbs_boot_t;

endpackage : cbs_pkg

// File: logic/cbs_i2c_target.sv
`timescale 1ns/1ps
module cbs_i2c_target
    import cbs_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                ce,
    input  wire logic                scl_s,
    input  wire logic                sda_s,
    input  wire logic [STATUS_W-1:0] status_byte,
    output logic                     sda_oe,
    output logic                     read_done
);
    // ========================================================
    // Bus condition detection
    // ========================================================
    logic scl_q;
    logic sda_q;
    wire  scl_rise = scl_s & ~scl_q;
    wire  scl_fall = ~scl_s & scl_q;
    wire  start_c  = scl_s & scl_q & sda_q & ~sda_s;
    wire  stop_c   = scl_s & scl_q & ~sda_q & sda_s;

    typedef enum logic [2:0] {
        CBS_TG_IDLE,
        CBS_TG_ADDR,
        CBS_TG_ACK,
        CBS_TG_TX,
        CBS_TG_RX_ACK,
        CBS_TG_WR
    } cbs_tg_t;

    cbs_tg_t       state_q;
    logic [3:0]    bit_q;
    logic [7:0]    shift_q;
    logic          rd_q;
    logic          ack_hi_q;

    wire addr_hit = (shift_q[7:1] == TARGET_ADDR);

    always_ff @(posedge clk) begin
        if (reset) begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            state_q   <= CBS_TG_IDLE;
            bit_q     <= 4'h0;
            shift_q   <= 8'h00;
            rd_q      <= 1'b0;
            sda_oe    <= 1'b0;
            read_done <= 1'b0;
            ack_hi_q  <= 1'b0;
        end else if (ce) begin
            scl_q     <= scl_s;
            sda_q     <= sda_s;
            read_done <= 1'b0;
            if (start_c) begin
                state_q <= CBS_TG_ADDR;
                bit_q   <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (stop_c) begin
                state_q <= CBS_TG_IDLE;
                sda_oe  <= 1'b0;
            end else begin
                unique case (state_q)
                    CBS_TG_IDLE: begin
                    end
                    CBS_TG_ADDR: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_q   <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            // Only our own address is acknowledged.
                            if (addr_hit) begin
                                sda_oe  <= 1'b1;
                                rd_q    <= shift_q[0];
                                state_q <= CBS_TG_ACK;
                            end else begin
                                state_q <= CBS_TG_IDLE;
                            end
                        end
                    end
                    CBS_TG_ACK: begin
                        if (scl_fall) begin
                            bit_q <= 4'h0;
                            if (rd_q) begin
                                shift_q <= status_byte;
                                sda_oe  <= ~status_byte[7];
                                state_q <= CBS_TG_TX;
                            end else begin
                                sda_oe  <= 1'b0;
                                state_q <= CBS_TG_WR;
                            end
                        end
                    end
                    CBS_TG_TX: begin
                        if (scl_fall) begin
                            bit_q   <= bit_q + 4'h1;
                            shift_q <= {shift_q[6:0], 1'b0};
                            if (bit_q == 4'h7) begin
                                sda_oe  <= 1'b0;
                                state_q <= CBS_TG_RX_ACK;
                            end else begin
                                sda_oe  <= ~shift_q[6];
                            end
                        end
                    end
                    CBS_TG_RX_ACK: begin
                        if (scl_rise) begin
                            ack_hi_q  <= sda_s;
                            read_done <= 1'b1;
                        end else if (scl_fall) begin
                            // Controller ACK asks for the byte again.
                            if (!ack_hi_q) begin
                                shift_q <= status_byte;
                                sda_oe  <= ~status_byte[7];
                                bit_q   <= 4'h0;
                                state_q <= CBS_TG_TX;
                            end else begin
                                state_q <= CBS_TG_IDLE;
                            end
                        end
                    end
                    CBS_TG_WR: begin
                        // Writes carry no meaning; bytes are acked.
                        if (scl_rise) begin
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            sda_oe  <= 1'b1;
                            state_q <= CBS_TG_ACK;
                        end
                    end
                    default: begin
                        state_q <= CBS_TG_IDLE;
                    end
                endcase
            end
        end
    end
endmodule : cbs_i2c_target

// File: verification/cbs_companion_chk.sv
`timescale 1ns/1ps
// ====
// Port checker
module cbs_companion_chk
    import cbs_pkg::*;
#(
    parameter int HOLD_CYC = HOLD_CYCLES
)
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       ce,
    input wire logic       cfg_load_busy,
    input wire logic       companion_supply_rail,
    input wire logic       release_on_boot_en,
    input wire logic       system_boot_ok,
    input wire logic       flash_grant_companion,
    input wire logic       companion_hold_line_n,
    input wire logic       attached,
    input wire logic       plug_flipped,
    input wire logic       dp_mode,
    input wire logic       fast_link_mode,
    input wire logic       dual_mode_dock,
    input wire logic       ext_power_good,
    input wire logic       mux_route_aux_sel,
    input wire logic       mux_route_link_sel,
    input wire logic       mux_gate_aux_path,
    input wire logic       mux_gate_sideband_link,
    input wire logic       sink_power_path,
    input wire logic       source_power_path,
    input wire logic [2:0] pdo_index,
    input wire logic       pdo_is_sink,
    input wire logic [2:0] pdo_count,
    input wire logic [9:0] pdo_mv50,
    input wire logic [9:0] pdo_ma10
);
    logic        loaded_q;
    logic [10:0] sup_cnt_q;

    // The supply count saturates so a long powered run never wraps to zero.
    always_ff @(posedge clk) begin
        if (reset) begin
            loaded_q  <= 1'b0;
            sup_cnt_q <= 11'h000;
        end else if (ce) begin
            loaded_q  <= loaded_q | !cfg_load_busy;
            sup_cnt_q <= !companion_supply_rail ? 11'h000 :
                         sup_cnt_q + {10'h000, ~&sup_cnt_q};
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_grant_after_load: assert property (
        flash_grant_companion |-> loaded_q) else $error("early grant");
    a_hold_in_load: assert property (
        !loaded_q |-> !companion_hold_line_n) else $error("early release");
    a_hold_min_time: assert property (
        $rose(companion_hold_line_n) |-> sup_cnt_q >= HOLD_CYC)
        else $error("hold released too soon after supply");
    a_hold_on_drop: assert property (
        !companion_supply_rail [*5] |->
        !companion_hold_line_n && !flash_grant_companion)
        else $error("hold not reasserted on supply loss");
    a_hold_boot_gate: assert property (
        (release_on_boot_en && !system_boot_ok) [*4] |->
        !companion_hold_line_n) else $error("release before boot");
    a_route_flip: assert property (
        ce |=> mux_route_aux_sel == $past(attached && plug_flipped) &&
        mux_route_link_sel == mux_route_aux_sel)
        else $error("route selects wrong");
    a_gate_paths: assert property (
        ce |=> mux_gate_aux_path == $past(attached && dp_mode) &&
        mux_gate_sideband_link == $past(attached && fast_link_mode))
        else $error("mux gates wrong");
    a_power_paths: assert property (
        ce |=> sink_power_path == $past(dual_mode_dock && !ext_power_good)
        && source_power_path ==
        $past(dual_mode_dock && ext_power_good && attached))
        else $error("power path wrong");
    a_src_offer: assert property (
        ce && !pdo_is_sink && pdo_index == 3'h0 |=> pdo_count == 3'h1 &&
        pdo_mv50 == 10'h064 && pdo_ma10 == 10'h12C)
        else $error("source offer wrong");
    a_snk_offer: assert property (
        ce && pdo_is_sink |=> pdo_count == 3'h4 && pdo_ma10 ==
        ($past(pdo_index) > 3'h3 ? 10'h000 : 10'h12C))
        else $error("sink offer wrong");
endmodule : cbs_companion_chk

bind cbs_companion_ctrl cbs_companion_chk #(.HOLD_CYC(HOLD_CYC)) chk_u (
    .clk(clk), .reset(reset), .ce(ce), .cfg_load_busy(cfg_load_busy),
    .companion_supply_rail(companion_supply_rail),
    .release_on_boot_en(release_on_boot_en),
    .system_boot_ok(system_boot_ok),
    .flash_grant_companion(flash_grant_companion),
    .companion_hold_line_n(companion_hold_line_n), .attached(attached),
    .plug_flipped(plug_flipped), .dp_mode(dp_mode),
    .fast_link_mode(fast_link_mode), .dual_mode_dock(dual_mode_dock),
    .ext_power_good(ext_power_good), .mux_route_aux_sel(mux_route_aux_sel),
    .mux_route_link_sel(mux_route_link_sel),
    .mux_gate_aux_path(mux_gate_aux_path),
    .mux_gate_sideband_link(mux_gate_sideband_link),
    .sink_power_path(sink_power_path),
    .source_power_path(source_power_path), .pdo_index(pdo_index),
    .pdo_is_sink(pdo_is_sink), .pdo_count(pdo_count),
    .pdo_mv50(pdo_mv50), .pdo_ma10(pdo_ma10)
);

// File: verification/cbs_link_partner.sv
`timescale 1ns/1ps
// ====
// Companion controller reading status over the target port
module cbs_link_partner (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [6:0] addr,
    input  wire logic       sda,
    output logic            scl,
    output logic            pull,
    output logic [7:0]      rd_byte,
    output logic            rd_ack,
    output logic            rd_done
);
    // Ten cycles a phase keeps well above the slowest target sampling.
    task automatic half;
        repeat (10) @(negedge clk);
    endtask : half

    task automatic put(input logic b);
        pull = !b;
        half();
        scl = 1'b1;
        half();
        scl = 1'b0;
    endtask : put

    initial begin
        scl = 1'b1;
        pull = 1'b0;
        rd_byte = 8'h00;
        rd_ack = 1'b0;
        rd_done = 1'b0;
        forever begin
            @(negedge clk iff go);
            rd_byte = 8'h00;
            pull = 1'b1;
            half();
            scl = 1'b0;
            for (int i = 0; i < 8; i++) begin
                put(i < 7 ? addr[6 - i] : 1'b1);
            end
            put(1'b1);
            // Sampled as the clock falls, before the target can react.
            rd_ack = !sda;
            for (int i = 0; i < 8 && rd_ack; i++) begin
                put(1'b1);
                rd_byte = {rd_byte[6:0], sda};
            end
            if (rd_ack) begin
                put(1'b1);
            end
            pull = 1'b1;
            half();
            scl = 1'b1;
            half();
            pull = 1'b0;
            half();
            rd_done <= 1'b1;
            @(negedge clk);
            rd_done <= 1'b0;
        end
    end
endmodule : cbs_link_partner

// File: verification/companion_boot_and_sideband_ctrl_tb_top.sv
`timescale 1ns/1ps
module companion_boot_and_sideband_ctrl_tb_top;
    import cbs_pkg::*;
    localparam int HC = 5;
    logic        clk, reset, ce, busy, rail, rbe, boot_ok, go, snk;
    logic        att, flip, dp, fast, usb3, dual, ext;
    logic [2:0]  pidx;
    logic [6:0]  addr;
    logic [1:0]  kind;
    logic [31:0] r;
    logic [31:0] exp_q[$];
    wire         grant, hold_n, rs_a, rs_l, g_aux, g_lnk, p_snk, p_src, irq;
    wire         sda_o, sda_oe, scl, pull, rd_ack, rd_done, sda_w;
    wire  [2:0]  pcnt;
    wire  [9:0]  mv, ma;
    wire  [7:0]  rd_byte;
    wire  [31:0] seen_v;
    int          miscompares, tests_run;

    assign sda_w = !pull && (sda_oe ? sda_o : 1'b1);
    assign seen_v = {3'h0, rs_a, rs_l, g_aux, g_lnk, p_snk, p_src,
                     pcnt, mv, ma};

    cbs_companion_ctrl #(.HOLD_CYC(HC)) dut_u (
        .clk(clk), .reset(reset), .ce(ce), .cfg_load_busy(busy),
        .companion_supply_rail(rail), .release_on_boot_en(rbe),
        .system_boot_ok(boot_ok), .flash_grant_companion(grant),
        .companion_hold_line_n(hold_n), .attached(att), .plug_flipped(flip),
        .dp_mode(dp), .fast_link_mode(fast), .usb3_mode(usb3),
        .dual_mode_dock(dual), .ext_power_good(ext),
        .mux_route_aux_sel(rs_a), .mux_route_link_sel(rs_l),
        .mux_gate_aux_path(g_aux), .mux_gate_sideband_link(g_lnk),
        .sink_power_path(p_snk), .source_power_path(p_src),
        .companion_irq(irq), .target_scl(scl), .target_sda_in(sda_w),
        .target_sda_out(sda_o), .target_sda_oe(sda_oe), .pdo_index(pidx),
        .pdo_is_sink(snk), .pdo_count(pcnt), .pdo_mv50(mv), .pdo_ma10(ma)
    );

    cbs_link_partner part_u (
        .clk(clk), .go(go), .addr(addr), .sda(sda_w), .scl(scl), .pull(pull),
        .rd_byte(rd_byte), .rd_ack(rd_ack), .rd_done(rd_done)
    );

    // ====
    // Checking
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [22:0] pdo_exp(input logic s, input logic [2:0] i);
        logic [9:0] v;
        v = i == 3'h0 ? 10'h064 : i == 3'h1 ? 10'h0B4 :
            i == 3'h2 ? 10'h12C : 10'h190;
        if (!s) begin
            return i == 3'h0 ? {3'h1, 10'h064, 10'h12C} : {3'h1, 20'h0};
        end
        return i > 3'h3 ? {3'h4, 20'h0} : {3'h4, v, 10'h12C};
    endfunction : pdo_exp

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic wait_hold(input int lo, input int hi);
        int n = 0;
        while (hold_n !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        check({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask : wait_hold

    task automatic i2c_rd(input logic [6:0] a, input logic [31:0] e);
        int n = 0;
        exp_q.push_back(e);
        addr <= a;
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        while (rd_done !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        cyc(2);
    endtask : i2c_rd

    always @(negedge clk) begin
        if (kind == 2'h1) begin
            check(seen_v, exp_q.pop_front());
        end
        if (rd_done === 1'b1) begin
            check({23'h0, rd_ack, rd_byte}, exp_q.pop_front());
        end
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    // ====
    // Scenarios
    initial begin
        {reset, ce, busy} = 3'h7;
        {rail, rbe, boot_ok, go, snk, att, flip} = 7'h00;
        {dp, fast, usb3, dual, ext, pidx, kind} = 10'h000;
        addr = 7'h38;
        void'($urandom(32'h1AAC));
        cyc(6);
        reset <= 1'b0;
        cyc(3);
        rail <= 1'b1;
        cyc(10);
        check({30'h0, grant, hold_n}, 32'h0);
        busy <= 1'b0;
        wait_hold(HC + 1, HC + 6);
        check({31'h0, grant}, 32'h1);
        rail <= 1'b0;
        cyc(6);
        check({30'h0, grant, hold_n}, 32'h0);
        rail <= 1'b1;
        cyc(HC);
        rail <= 1'b0;
        cyc(4);
        rail <= 1'b1;
        wait_hold(HC + 3, HC + 8);
        rbe <= 1'b1;
        cyc(4);
        check({31'h0, hold_n}, 32'h0);
        boot_ok <= 1'b1;
        wait_hold(1, 4);
        rbe <= 1'b0;
        for (int k = 0; k < 60; k++) begin
            r = $urandom;
            {att, flip, dp, fast, usb3, dual, ext, snk, pidx} <= r[10:0];
            kind <= 2'h1;
            exp_q.push_back({3'h0, {2{r[10] & r[9]}}, r[10] & r[8],
                r[10] & r[7], r[5] & !r[4], r[5] & r[4] & r[10],
                pdo_exp(r[3], r[2:0])});
            @(negedge clk);
        end
        kind <= 2'h0;
        {att, flip, dp, fast, usb3, dual, ext} <= 7'h00;
        cyc(3);
        {att, flip, dp, fast, usb3, dual, ext} <= 7'h6E;
        cyc(4);
        check({31'h0, irq}, 32'h1);
        i2c_rd(7'h38, 32'h17B);
        cyc(4);
        check({31'h0, irq}, 32'h0);
        i2c_rd(7'h39, 32'h000);
        ce <= 1'b0;
        att <= 1'b0;
        cyc(3);
        check({30'h0, rs_a, g_lnk}, 32'h3);
        ce <= 1'b1;
        cyc(2);
        check({30'h0, rs_a, g_lnk}, 32'h0);
        report_and_stop();
    end
endmodule : companion_boot_and_sideband_ctrl_tb_top
